// ### rtl/rdc_regulator_dvs_control.sv
// Control register bank for third-buck voltage scaling and the buck-boost.
// Assumes a serial-port engine on clk_i presenting byte reads and writes,
// and raw control pins from outside that are synchronised here.
`timescale 1ns/100ps
`include "rdc_defs.svh"

module rdc_regulator_dvs_control #(
    parameter int CLK_PERIOD_NS = `RDC_CLK_PERIOD_NS,
    parameter int RAMP_STEP_NS  = `RDC_RAMP_STEP_NS,
    parameter int PIN_COUNT     = 8
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // Register access from the serial-port engine
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic [7:0]           reg_wdata_i,
    output logic      [7:0]           reg_rdata_o,
    // Raw control pins
    input  wire logic [PIN_COUNT-1:0] multipurpose_control_pin_i,
    // Third buck context
    input  wire logic [5:0]           serial_voltage_code_i,
    input  wire logic                 scaling_transition_i,
    output logic                      dvs_active_o,
    output logic                      dvs_serial_mode_o,
    output logic      [5:0]           third_buck_scaling_code_o,
    output logic                      scaling_valley_1000ma_o,
    output logic                      scaling_peak_max_o,
    // Buck-boost context
    input  wire logic [PIN_COUNT-1:0] bb_pin_select_bits_i,
    input  wire logic                 boot_at_0_i,
    input  wire logic                 boot_at_25_i,
    input  wire logic                 boot_at_50_i,
    input  wire logic                 boot_done_i,
    input  wire logic                 hard_reset_mode_i,
    input  wire logic                 shutdown_mode_i,
    output logic                      bb_enable_o,
    output logic                      bb_active_discharge_o,
    output logic                      bb_passive_discharge_o,
    output logic      [5:0]           bb_applied_code_o,
    output logic                      bb_ramping_o,
    output logic                      bb_buck_only_o,
    output logic                      bb_slow_edge_o,
    output logic                      bb_peak_from_fields_o,
    output logic      [3:0]           bb_nominal_peak_code_o,
    output logic      [3:0]           bb_peak_headroom_code_o
);

    localparam int RAMP_CYCLES_RAW = RAMP_STEP_NS / CLK_PERIOD_NS;
    localparam int RAMP_CYCLES     = (RAMP_CYCLES_RAW < 1) ? 1 : RAMP_CYCLES_RAW;
    localparam int RAMP_W          = $clog2(RAMP_CYCLES + 1);
    localparam logic [RAMP_W-1:0] RAMP_LAST = RAMP_W'(RAMP_CYCLES - 1);

    // Pair code to pin indices; bit 6 marks a valid pair
    function automatic logic [6:0] pair_decode(input logic [4:0] code);
        logic [6:0] res;
        int         idx;
        res = 7'h00;
        idx = 1;
        for (int a = 0; a < 7; a++) begin
            for (int b = a + 1; b < 8; b++) begin
                if (5'(idx) == code) begin
                    res = {1'b1, 3'(a), 3'(b)};
                end
                idx++;
            end
        end
        return res;
    endfunction

    // Registers
    logic [7:0] scale_cfg_q;
    logic [5:0] alt_v_q [4];
    logic [5:0] readback_q;
    logic [7:0] bb_ena_q;
    logic [7:0] bb_cfg_q;
    logic [5:0] bb_vset_q;
    logic [7:0] bb_peak_q;
    logic [7:0] rdata_q;

    // Pin synchroniser
    logic [PIN_COUNT-1:0] pin_meta_q;
    logic [PIN_COUNT-1:0] pin_sync_q;

    // Ramp engine
    rdc_pkg::rdc_ramp_type ramp_state_q;
    logic [RAMP_W-1:0]     ramp_cnt_q;
    logic [5:0]            bb_code_q;

    // Scaling outputs
    logic       dvs_active_q;
    logic       dvs_serial_q;
    logic [5:0] scale_code_q;

    // Decode
    wire        wr_scale   = reg_wr_i && (reg_addr_i == `RDC_OFS_SCALE_CFG);
    wire        wr_alt0    = reg_wr_i && (reg_addr_i == `RDC_OFS_ALT_V0);
    wire        wr_alt1    = reg_wr_i && (reg_addr_i == `RDC_OFS_ALT_V1);
    wire        wr_alt2    = reg_wr_i && (reg_addr_i == `RDC_OFS_ALT_V2);
    wire        wr_alt3    = reg_wr_i && (reg_addr_i == `RDC_OFS_ALT_V3);
    wire        wr_bb_ena  = reg_wr_i && (reg_addr_i == `RDC_OFS_BB_ENABLE);
    wire        wr_bb_cfg  = reg_wr_i && (reg_addr_i == `RDC_OFS_BB_CFG);
    wire        wr_bb_vset = reg_wr_i && (reg_addr_i == `RDC_OFS_BB_VSET);
    wire        wr_bb_peak = reg_wr_i && (reg_addr_i == `RDC_OFS_BB_PEAK);

    // Third buck scaling selection
    wire [4:0]  pair_code   = scale_cfg_q[4:0];
    wire [6:0]  pair_info   = pair_decode(pair_code);
    wire        pair_valid  = pair_info[6];
    wire        serial_mode = (pair_code == `RDC_PAIR_SERIAL);
    // Zero and reserved codes both leave scaling off
    wire        scaling_on  = pair_valid || serial_mode;
    wire [1:0]  pin_index   = {pin_sync_q[pair_info[5:3]],
                               pin_sync_q[pair_info[2:0]]};
    wire [5:0]  pin_code    = alt_v_q[pin_index];
    // Codes leave as raw steps; the analog side scales them
    wire [5:0]  scale_code_d = serial_mode ? serial_voltage_code_i
                                           : pin_code;

    // Buck-boost enable
    rdc_pkg::rdc_seq_type   seq_sel;
    rdc_pkg::rdc_ensel_type en_sel;
    assign seq_sel = rdc_pkg::rdc_seq_type'(bb_ena_q[7:5]);
    assign en_sel  = rdc_pkg::rdc_ensel_type'(bb_ena_q[1:0]);

    wire        pin_enable = |(pin_sync_q & bb_pin_select_bits_i);
    logic       soft_enable;
    logic       bb_enable_d;

    always_comb begin
        case (en_sel)
            rdc_pkg::RDC_EN_ON:   soft_enable = 1'b1;
            rdc_pkg::RDC_EN_PINS: soft_enable = pin_enable;
            default:              soft_enable = 1'b0;
        endcase
    end

    always_comb begin
        case (seq_sel)
            rdc_pkg::RDC_SEQ_BOOT0:  bb_enable_d = boot_at_0_i;
            rdc_pkg::RDC_SEQ_BOOT25: bb_enable_d = boot_at_25_i;
            rdc_pkg::RDC_SEQ_BOOT50: bb_enable_d = boot_at_50_i;
            rdc_pkg::RDC_SEQ_SOFT:   bb_enable_d = boot_done_i && soft_enable;
            default:                 bb_enable_d = 1'b0;
        endcase
    end

    // Discharge; shutdown also forces active (not passive) discharge since select 00 only skips it otherwise
    wire act_dsc_d = hard_reset_mode_i || shutdown_mode_i ||
                     (bb_cfg_q[`RDC_BIT_ACT_DSC] && !bb_enable_d);
    wire psv_dsc_d = hard_reset_mode_i ||
                     (bb_cfg_q[`RDC_BIT_PSV_DSC] && !bb_enable_d);

    wire lookup_dis = bb_cfg_q[`RDC_BIT_LOOKUP_DIS];
    wire ramp_en    = bb_cfg_q[`RDC_BIT_RAMP_EN];
    wire step_up    = ramp_en && (bb_vset_q > bb_code_q);
    wire ramp_tick  = (ramp_cnt_q == RAMP_LAST);

    // Read mux, reserved bits zero
    logic [7:0] rdata_d;
    always_comb begin
        case (reg_addr_i)
            `RDC_OFS_SCALE_CFG: rdata_d = scale_cfg_q;
            `RDC_OFS_ALT_V0:    rdata_d = {2'b00, alt_v_q[0]};
            `RDC_OFS_ALT_V1:    rdata_d = {2'b00, alt_v_q[1]};
            `RDC_OFS_ALT_V2:    rdata_d = {2'b00, alt_v_q[2]};
            `RDC_OFS_ALT_V3:    rdata_d = {2'b00, alt_v_q[3]};
            `RDC_OFS_READBACK:  rdata_d = {2'b00, readback_q};
            `RDC_OFS_BB_ENABLE: rdata_d = bb_ena_q;
            `RDC_OFS_BB_CFG:    rdata_d = bb_cfg_q;
            `RDC_OFS_BB_VSET:   rdata_d = {2'b00, bb_vset_q};
            `RDC_OFS_BB_PEAK:   rdata_d = bb_peak_q;
            default:            rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= multipurpose_control_pin_i;
            pin_sync_q <= pin_meta_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scale_cfg_q <= `RDC_RST_SCALE_CFG;
            bb_ena_q    <= `RDC_RST_BB_ENABLE;
            bb_cfg_q    <= `RDC_RST_BB_CFG;
            bb_vset_q   <= `RDC_RST_BB_VSET;
            bb_peak_q   <= `RDC_RST_BB_PEAK;
        end else begin
            if (wr_scale) begin
                scale_cfg_q <= reg_wdata_i & `RDC_MASK_SCALE_CFG;
            end
            if (wr_bb_ena) begin
                bb_ena_q <= reg_wdata_i & `RDC_MASK_BB_ENABLE;
            end
            if (wr_bb_cfg) begin
                bb_cfg_q <= reg_wdata_i & `RDC_MASK_BB_CFG;
            end
            if (wr_bb_vset) begin
                bb_vset_q <= reg_wdata_i[5:0];
            end
            if (wr_bb_peak) begin
                bb_peak_q <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 4; i++) begin
                alt_v_q[i] <= `RDC_RST_ALT_V;
            end
        end else begin
            if (wr_alt0) alt_v_q[0] <= reg_wdata_i[5:0];
            if (wr_alt1) alt_v_q[1] <= reg_wdata_i[5:0];
            if (wr_alt2) alt_v_q[2] <= reg_wdata_i[5:0];
            if (wr_alt3) alt_v_q[3] <= reg_wdata_i[5:0];
        end
    end

    // Readback holds the last serial code; no write path exists
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            readback_q <= `RDC_RST_READBACK;
        end else if (serial_mode) begin
            readback_q <= serial_voltage_code_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_i) begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dvs_active_q <= 1'b0;
            dvs_serial_q <= 1'b0;
            scale_code_q <= 6'h00;
        end else begin
            dvs_active_q <= scaling_on;
            dvs_serial_q <= serial_mode;
            scale_code_q <= scaling_on ? scale_code_d : 6'h00;
        end
    end

    // Ramp engine: the step timer restarts with each new climb
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ramp_state_q <= rdc_pkg::RDC_RAMP_IDLE;
            ramp_cnt_q   <= '0;
            bb_code_q    <= `RDC_RST_BB_VSET;
        end else begin
            case (ramp_state_q)
                rdc_pkg::RDC_RAMP_IDLE: begin
                    ramp_cnt_q <= '0;
                    if (step_up) begin
                        ramp_state_q <= rdc_pkg::RDC_RAMP_STEP;
                    end else begin
                        bb_code_q <= bb_vset_q;
                    end
                end
                rdc_pkg::RDC_RAMP_STEP: begin
                    if (!step_up) begin
                        ramp_state_q <= rdc_pkg::RDC_RAMP_IDLE;
                        bb_code_q    <= bb_vset_q;
                    end else if (ramp_tick) begin
                        ramp_cnt_q <= '0;
                        bb_code_q  <= bb_code_q + 6'h01;
                    end else begin
                        ramp_cnt_q <= ramp_cnt_q + 1'b1;
                    end
                end
                default: ramp_state_q <= rdc_pkg::RDC_RAMP_IDLE;
            endcase
        end
    end

    // Buck-boost outputs registered to keep them glitch free
    logic       bb_en_q;
    logic       act_dsc_q;
    logic       psv_dsc_q;
    logic [3:0] nom_peak_q;
    logic [3:0] head_peak_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bb_en_q     <= 1'b0;
            act_dsc_q   <= 1'b0;
            psv_dsc_q   <= 1'b0;
            nom_peak_q  <= 4'h0;
            head_peak_q <= 4'h0;
        end else begin
            bb_en_q     <= bb_enable_d;
            act_dsc_q   <= act_dsc_d;
            psv_dsc_q   <= psv_dsc_d;
            nom_peak_q  <= lookup_dis ? bb_peak_q[3:0] : 4'h0;
            head_peak_q <= lookup_dis ? bb_peak_q[7:4] : 4'h0;
        end
    end

    assign reg_rdata_o               = rdata_q;
    assign dvs_active_o              = dvs_active_q;
    assign dvs_serial_mode_o         = dvs_serial_q;
    assign third_buck_scaling_code_o = scale_code_q;
    assign scaling_valley_1000ma_o   = scale_cfg_q[`RDC_BIT_VALLEY_SEL];
    assign scaling_peak_max_o        = scale_cfg_q[`RDC_BIT_PEAK_MAX] &&
                                       scaling_transition_i;
    assign bb_enable_o               = bb_en_q;
    assign bb_active_discharge_o     = act_dsc_q;
    assign bb_passive_discharge_o    = psv_dsc_q;
    assign bb_applied_code_o         = bb_code_q;
    assign bb_ramping_o              = (ramp_state_q == rdc_pkg::RDC_RAMP_STEP);
    assign bb_buck_only_o            = bb_cfg_q[`RDC_BIT_TOPOLOGY];
    assign bb_slow_edge_o            = bb_cfg_q[`RDC_BIT_SLOW_EDGE];
    assign bb_peak_from_fields_o     = lookup_dis;
    assign bb_nominal_peak_code_o    = nom_peak_q;
    assign bb_peak_headroom_code_o   = head_peak_q;

endmodule // rdc_regulator_dvs_control

// ### rtl/rdc_defs.svh
// Register offsets, field positions, reset values and timing for the
// regulator scaling control bank. Included by the package and the design.
`ifndef RDC_DEFS_SVH
`define RDC_DEFS_SVH

`define RDC_OFS_SCALE_CFG      8'h4E
`define RDC_OFS_ALT_V0         8'h4F
`define RDC_OFS_ALT_V1         8'h50
`define RDC_OFS_ALT_V2         8'h51
`define RDC_OFS_ALT_V3         8'h52
`define RDC_OFS_READBACK       8'h53
`define RDC_OFS_BB_ENABLE      8'h54
`define RDC_OFS_BB_CFG         8'h55
`define RDC_OFS_BB_VSET        8'h56
`define RDC_OFS_BB_PEAK        8'h57

`define RDC_RST_SCALE_CFG      8'h20
`define RDC_RST_ALT_V          6'h00
`define RDC_RST_READBACK       6'h00
`define RDC_RST_BB_ENABLE      8'h00
`define RDC_RST_BB_CFG         8'h05
`define RDC_RST_BB_VSET        6'h00
`define RDC_RST_BB_PEAK        8'h00

`define RDC_MASK_SCALE_CFG     8'hBF
`define RDC_MASK_BB_ENABLE     8'hE3
`define RDC_MASK_BB_CFG        8'h9F

`define RDC_BIT_VALLEY_SEL     7
`define RDC_BIT_PEAK_MAX       5
`define RDC_BIT_LOOKUP_DIS     7
`define RDC_BIT_SLOW_EDGE      4
`define RDC_BIT_ACT_DSC        3
`define RDC_BIT_RAMP_EN        2
`define RDC_BIT_TOPOLOGY       1
`define RDC_BIT_PSV_DSC        0

`define RDC_PAIR_OFF           5'h00
`define RDC_PAIR_SERIAL        5'h1D

`define RDC_RAMP_STEP_NS       20000
`define RDC_CLK_PERIOD_NS      100

`endif

// ### rtl/rdc_pkg.sv
// Types for the regulator scaling control bank.
// Assumes rdc_defs.svh is on the include path.
`include "rdc_defs.svh"

package rdc_pkg;

    typedef enum logic [2:0] {
        RDC_SEQ_OFF,
        RDC_SEQ_RSVD1,
        RDC_SEQ_BOOT0,
        RDC_SEQ_BOOT25,
        RDC_SEQ_BOOT50,
        RDC_SEQ_RSVD5,
        RDC_SEQ_RSVD6,
        RDC_SEQ_SOFT
    } rdc_seq_type;

    typedef enum logic [1:0] {
        RDC_EN_OFF,
        RDC_EN_ON,
        RDC_EN_PINS,
        RDC_EN_RSVD
    } rdc_ensel_type;

    typedef enum logic {
        RDC_RAMP_IDLE,
        RDC_RAMP_STEP
    } rdc_ramp_type;

endpackage

// ### testbench/rdc_regulator_dvs_control_chk.sv
// Port assertions for the regulator scaling control bank.
// Assumes binding onto rdc_regulator_dvs_control, one clock, sync reset.
`timescale 1ns/100ps
module rdc_chk #(
    parameter int CLK_PERIOD_NS = 100,
    parameter int RAMP_STEP_NS  = 20000
) (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       scaling_transition_i,
    input wire logic       hard_reset_mode_i,
    input wire logic       dvs_active_o,
    input wire logic       dvs_serial_mode_o,
    input wire logic [5:0] third_buck_scaling_code_o,
    input wire logic       scaling_valley_1000ma_o,
    input wire logic       scaling_peak_max_o,
    input wire logic       bb_enable_o,
    input wire logic       bb_active_discharge_o,
    input wire logic       bb_passive_discharge_o,
    input wire logic [5:0] bb_applied_code_o,
    input wire logic       bb_ramping_o,
    input wire logic       bb_buck_only_o,
    input wire logic       bb_slow_edge_o,
    input wire logic       bb_peak_from_fields_o,
    input wire logic [3:0] bb_nominal_peak_code_o,
    input wire logic [3:0] bb_peak_headroom_code_o
);
    localparam int STEP_CYC = RAMP_STEP_NS / CLK_PERIOD_NS;
    logic [15:0] gap_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Cycles since the applied code last moved while ramping
    always_ff @(posedge clk_i) begin
        if (rst_i || !bb_ramping_o || $changed(bb_applied_code_o)) gap_q <= 16'h0000;
        else gap_q <= gap_q + 16'h0001;
    end
    property p_valley;
        reg_wr_i && reg_addr_i == 8'h4E |=>
            {scaling_valley_1000ma_o, 7'h00} == ($past(reg_wdata_i) & 8'h80);
    endproperty
    a_valley: assert property (p_valley) else $error("valley select wrong");
    property p_peak; scaling_peak_max_o |-> scaling_transition_i; endproperty
    a_peak: assert property (p_peak) else $error("peak max outside transition");
    property p_off; !dvs_active_o [*2] |-> third_buck_scaling_code_o == 6'h00; endproperty
    a_off: assert property (p_off) else $error("code while scaling off");
    property p_serial; dvs_serial_mode_o |-> dvs_active_o; endproperty
    a_serial: assert property (p_serial) else $error("serial mode not active");
    property p_hard; hard_reset_mode_i |=> bb_active_discharge_o && bb_passive_discharge_o;
    endproperty
    a_hard: assert property (p_hard) else $error("no discharge in hard reset");
    property p_psv; bb_enable_o && !$past(hard_reset_mode_i) |-> !bb_passive_discharge_o;
    endproperty
    a_psv: assert property (p_psv) else $error("passive discharge while on");
    property p_lookup;
        !bb_peak_from_fields_o [*2] |->
            bb_nominal_peak_code_o == 4'h0 && bb_peak_headroom_code_o == 4'h0;
    endproperty
    a_lookup: assert property (p_lookup) else $error("peak fields leak");
    property p_cfg;
        reg_wr_i && reg_addr_i == 8'h55 |=> ($past(reg_wdata_i) & 8'h12) ==
            {3'b000, bb_slow_edge_o, 2'b00, bb_buck_only_o, 1'b0};
    endproperty
    a_cfg: assert property (p_cfg) else $error("mode or edge bit wrong");
    property p_one;
        bb_ramping_o && bb_applied_code_o > $past(bb_applied_code_o) |->
            bb_applied_code_o == $past(bb_applied_code_o) + 6'h01;
    endproperty
    a_one: assert property (p_one) else $error("ramp step not one count");
    property p_gap;
        bb_ramping_o && bb_applied_code_o > $past(bb_applied_code_o) |->
            gap_q inside {[STEP_CYC - 1:STEP_CYC]};
    endproperty
    a_gap: assert property (p_gap) else $error("ramp step spacing wrong");
    c_ramp: cover property ($rose(bb_ramping_o));
    c_serial: cover property (dvs_serial_mode_o);
    c_enable: cover property ($rose(bb_enable_o));
endmodule // rdc_chk

bind rdc_regulator_dvs_control rdc_chk #(
    .CLK_PERIOD_NS(CLK_PERIOD_NS),
    .RAMP_STEP_NS (RAMP_STEP_NS)
) rdc_chk_i (.*);

// ### testbench/rdc_host_model.sv
// Host software and control-pin driver model for the scaling bank.
// Assumes clk_i is the bank clock; outputs change just after its rising edge.
`timescale 1ns/100ps
module rdc_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o,
    output logic      [7:0] pins_o
);
    initial begin
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
        pins_o      = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == 8'h4E && v[4:0] > 5'h1D) v[4:0] = 5'h00; // Reserved pair codes
        if (a == 8'h56 && v[5:0] > 6'h3C) v[5:0] = 6'h3C; // Beyond full scale
        @(posedge clk_i);
        reg_wr_o    <= 1'b1;
        reg_addr_o  <= a;
        reg_wdata_o <= v;
        @(posedge clk_i);
        reg_wr_o <= 1'b0;
    endtask
    // Data arrives one edge after the strobe is taken
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_rd_o   <= 1'b1;
        reg_addr_o <= a;
        @(posedge clk_i);
        reg_rd_o <= 1'b0;
        @(posedge clk_i);
        d = reg_rdata_i;
    endtask
    task automatic set_pins(input logic [7:0] v);
        @(posedge clk_i);
        pins_o <= v;
    endtask
endmodule // rdc_host_model

// ### testbench/test_regulator_dvs_control.sv
// Self-checking bench for the regulator scaling control bank.
// Assumes the host model drives the register port and control pins.
`timescale 1ns/100ps
`define CHECK_EQ(nm, ex, gt) begin \
    comparisons++; \
    if ((gt) !== (ex)) begin \
        n_mismatch++; \
        $display("mismatch %s expected %h seen %h", nm, ex, gt); \
    end \
end
module test_regulator_dvs_control;
    localparam int STEP_CYC = 10;
    logic clk_i, rst_i, reg_wr_i, reg_rd_i, scaling_transition_i;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, multipurpose_control_pin_i;
    logic [7:0] bb_pin_select_bits_i;
    logic [5:0] serial_voltage_code_i, third_buck_scaling_code_o, bb_applied_code_o;
    logic boot_at_0_i, boot_at_25_i, boot_at_50_i, boot_done_i, hard_reset_mode_i;
    logic shutdown_mode_i, dvs_active_o, dvs_serial_mode_o, scaling_valley_1000ma_o;
    logic scaling_peak_max_o, bb_enable_o, bb_active_discharge_o, bb_passive_discharge_o;
    logic bb_ramping_o, bb_buck_only_o, bb_slow_edge_o, bb_peak_from_fields_o;
    logic [3:0] bb_nominal_peak_code_o, bb_peak_headroom_code_o;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] d;

    rdc_regulator_dvs_control #(.RAMP_STEP_NS(1000)) rdc_regulator_dvs_control_i (.*);
    rdc_host_model rdc_host_model_i (
        .clk_i      (clk_i),
        .reg_rdata_i(reg_rdata_o),
        .reg_wr_o   (reg_wr_i),
        .reg_rd_o   (reg_rd_i),
        .reg_addr_o (reg_addr_i),
        .reg_wdata_o(reg_wdata_i),
        .pins_o     (multipurpose_control_pin_i)
    );

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        rdc_host_model_i.wr(a, v);
    endtask
    task automatic t_regs();
        logic [7:0] rv [11] = '{8'h20, 0, 0, 0, 0, 0, 0, 8'h05, 0, 0, 0};
        logic [7:0] wv [11] = '{8'hFC, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                8'hFF, 8'hFC, 8'hFF, 8'hFF};
        logic [7:0] ev [11] = '{8'hBC, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h00, 8'hE3,
                                8'h9F, 8'h3C, 8'hFF, 8'h00};
        for (int i = 0; i < 11; i++) begin
            rdc_host_model_i.rd(8'h4E + i[7:0], d);
            `CHECK_EQ("reset_value", rv[i], d)
            wr(8'h4E + i[7:0], wv[i]);
        end
        for (int i = 0; i < 11; i++) begin
            rdc_host_model_i.rd(8'h4E + i[7:0], d);
            `CHECK_EQ("masked_value", ev[i], d)
        end
        rst_i <= 1'b1;
        wait_clk(3);
        rst_i <= 1'b0;
        $display("done regs");
    endtask
    task automatic t_pins();
        logic [5:0] alt [4] = '{6'h11, 6'h22, 6'h33, 6'h0A};
        logic [4:0] c;
        for (int i = 0; i < 4; i++) wr(8'h4F + i[7:0], {2'b00, alt[i]});
        wr(8'h4E, 8'hA0);
        scaling_transition_i <= 1'b1;
        wait_clk(2);
        `CHECK_EQ("valley_peak", 2'b11, {scaling_valley_1000ma_o, scaling_peak_max_o})
        wr(8'h4E, 8'h00);
        rdc_host_model_i.set_pins(8'hFF);
        wait_clk(4);
        `CHECK_EQ("off_code", 7'h00, {dvs_active_o, third_buck_scaling_code_o})
        `CHECK_EQ("valley_peak_off", 2'b00, {scaling_valley_1000ma_o, scaling_peak_max_o})
        for (int i = 0; i < 4; i++) begin
            wr(8'h4E, 8'h01);
            rdc_host_model_i.set_pins({6'h00, i[0], i[1]});
            wait_clk(4);
            `CHECK_EQ("index_code", alt[i], third_buck_scaling_code_o)
        end
        c = 5'h01;
        for (int a = 0; a < 7; a++) begin
            for (int b = a + 1; b < 8; b++) begin
                wr(8'h4E, {3'b000, c});
                rdc_host_model_i.set_pins(~(8'h01 << b));
                wait_clk(4);
                `CHECK_EQ("pair_code", 6'h33, third_buck_scaling_code_o)
                c++;
            end
        end
        serial_voltage_code_i <= 6'h2A;
        wr(8'h4E, 8'h1D);
        wr(8'h53, 8'h15);
        wait_clk(3);
        `CHECK_EQ("serial_code", 8'hEA, {dvs_serial_mode_o, dvs_active_o, third_buck_scaling_code_o})
        rdc_host_model_i.rd(8'h53, d);
        `CHECK_EQ("readback", 8'h2A, d)
        $display("done pins");
    endtask
    task automatic en_case(input logic [7:0] ena, input logic [3:0] boot, input logic ex);
        {boot_at_0_i, boot_at_25_i, boot_at_50_i, boot_done_i} <= boot;
        wr(8'h54, ena);
        wait_clk(4);
        `CHECK_EQ("bb_enable", ex, bb_enable_o)
    endtask
    task automatic t_enable();
        en_case(8'h40, 4'h8, 1'b1);
        en_case(8'h40, 4'h7, 1'b0);
        en_case(8'h60, 4'h4, 1'b1);
        en_case(8'h60, 4'hB, 1'b0);
        en_case(8'h80, 4'h2, 1'b1);
        en_case(8'h80, 4'hD, 1'b0);
        en_case(8'h00, 4'hF, 1'b0);
        en_case(8'hE1, 4'h0, 1'b0);
        en_case(8'hE1, 4'h1, 1'b1);
        en_case(8'hE0, 4'h1, 1'b0);
        en_case(8'hE3, 4'h1, 1'b0);
        bb_pin_select_bits_i <= 8'h28;
        rdc_host_model_i.set_pins(8'h08);
        en_case(8'hE2, 4'h1, 1'b1);
        rdc_host_model_i.set_pins(8'h10);
        en_case(8'hE2, 4'h1, 1'b0);
        rdc_host_model_i.set_pins(8'h20);
        en_case(8'hE2, 4'h1, 1'b1);
        $display("done enable");
    endtask
    task automatic dsc(input logic [7:0] cfg, input logic [2:0] ctl, input logic [1:0] ex);
        {hard_reset_mode_i, shutdown_mode_i} <= ctl[2:1];
        wr(8'h54, {7'h70, ctl[0]});
        wr(8'h55, cfg);
        wait_clk(3);
        `CHECK_EQ("discharge", ex, {bb_active_discharge_o, bb_passive_discharge_o})
    endtask
    task automatic t_discharge();
        dsc(8'h08, 3'b000, 2'b10);
        dsc(8'h01, 3'b000, 2'b01);
        dsc(8'h00, 3'b000, 2'b00);
        dsc(8'h00, 3'b100, 2'b11);
        dsc(8'h00, 3'b010, 2'b10);
        dsc(8'h09, 3'b001, 2'b00);
        hard_reset_mode_i <= 1'b0;
        shutdown_mode_i <= 1'b0;
        wr(8'h57, 8'hA5);
        wr(8'h55, 8'h00);
        wait_clk(3);
        `CHECK_EQ("table_peak", 8'h00, {bb_peak_headroom_code_o, bb_nominal_peak_code_o})
        wr(8'h55, 8'h92);
        wait_clk(3);
        `CHECK_EQ("field_peak", 8'hA5, {bb_peak_headroom_code_o, bb_nominal_peak_code_o})
        `CHECK_EQ("mode_bits", 3'b111, {bb_peak_from_fields_o, bb_slow_edge_o, bb_buck_only_o})
        $display("done discharge");
    endtask
    task automatic t_ramp();
        int n;
        wr(8'h55, 8'h00);
        wr(8'h56, 8'h05);
        wait_clk(3);
        `CHECK_EQ("direct_code", 6'h05, bb_applied_code_o)
        wr(8'h55, 8'h04);
        wr(8'h56, 8'h08);
        wait_clk(3);
        `CHECK_EQ("ramp_hold", 7'h45, {bb_ramping_o, bb_applied_code_o})
        for (n = 0; bb_applied_code_o !== 6'h06 && n < 100; n++) wait_clk(1);
        for (n = 0; bb_applied_code_o !== 6'h07 && n < 100; n++) wait_clk(1);
        `CHECK_EQ("step_cycles", STEP_CYC, n)
        wait_clk(STEP_CYC + 3);
        `CHECK_EQ("ramp_end", 7'h08, {bb_ramping_o, bb_applied_code_o})
        wr(8'h56, 8'h02);
        wait_clk(3);
        `CHECK_EQ("ramp_down", 7'h02, {bb_ramping_o, bb_applied_code_o})
        $display("done ramp");
    endtask

    initial begin
        rst_i = 1'b1;
        scaling_transition_i = 1'b0;
        serial_voltage_code_i = 6'h00;
        bb_pin_select_bits_i = 8'h00;
        {boot_at_0_i, boot_at_25_i, boot_at_50_i, boot_done_i} = 4'h0;
        hard_reset_mode_i = 1'b0;
        shutdown_mode_i = 1'b0;
        wait_clk(3);
        rst_i <= 1'b0;
        t_regs();
        t_pins();
        t_enable();
        t_discharge();
        t_ramp();
        print_verdict();
    end
endmodule // test_regulator_dvs_control
